//--- design/owc_consts.svh
`ifndef OWC_CONSTS_SVH
`define OWC_CONSTS_SVH

// Register byte offsets (low address bits only are decoded).
`define OWC_OSC_OFS 8'h00
`define OWC_LOW_POWER_MODE_SELECT_OFS 8'h04
`define OWC_STAT_OFS 8'h08
`define OWC_MASK_OFS 8'h0C

// Reset values.
`define OWC_OSC_RST 32'h80010030
`define OWC_LOW_POWER_MODE_SELECT_RST 32'h00000103

// Bits that software can store; bits 1 and 0 of the oscillator register are not stored.
`define OWC_OSC_WMASK 32'hFFFFFFFC
`define OWC_LOW_POWER_MODE_SELECT_WMASK 32'h000F0307

// Oscillator control fields.
`define OWC_CNT_HIGH_MSB 31
`define OWC_CNT_HIGH_LSB 20
`define OWC_WU_HS_SRC_BIT 19
`define OWC_HS_SRC_BIT 17
`define OWC_INT_HS_EN_BIT 16
`define OWC_CNT_LOW_MSB 15
`define OWC_CNT_LOW_LSB 14
`define OWC_HS_CLKIN_EN_BIT 11
`define OWC_LS_SRC_BIT 10
`define OWC_EXT_LS_EN_BIT 9
`define OWC_EXT_HS_EN_BIT 8
`define OWC_WU_SPEED_BIT 3
`define OWC_WU_FLAG_BIT 1
`define OWC_WU_START_BIT 0

// Standby control fields.
`define OWC_PIN_KEEP_BIT 16
`define OWC_LS_AFTER_BIT 9
`define OWC_HS_AFTER_BIT 8
`define OWC_LPM_MSB 2
`define OWC_LPM_LSB 0

// Interrupt status bits.
`define OWC_EV_DONE_BIT 0
`define OWC_EV_RESTART_BIT 1
`define OWC_EV_W 2

`endif

//--- design/owc_pkg.sv
package owc_pkg;

    typedef enum logic [2:0] {
        LPM_STOP = 3'h1,
        LPM_SLEEP = 3'h2,
        LPM_IDLE = 3'h3
    } lp_mode_e;

    typedef enum logic [1:0] {
        WU_IDLE = 2'h1,
        WU_COUNT = 2'h2
    } wu_state_e;

    typedef struct packed {
        wu_state_e state;
        logic done;
        logic [15:0] cnt;
        logic [15:0] target;
    } wu_s;

    typedef struct packed {
        logic [31:0] osc;
        logic [31:0] low_power_mode_select;
        logic [1:0] stat;
        logic [1:0] mask;
        logic irq;
        logic ph_wr;
        logic ph_rd;
        logic [7:0] ph_addr;
        logic ready;
        logic [31:0] rdata;
    } ctl_s;

endpackage

//--- design/warmup_counter.sv
`timescale 1ns/10ps
module warmup_counter (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Control
    input wire logic start_i,
    input wire logic tick_i,
    input wire logic [15:0] target_i,
    // Status
    output logic busy_o,
    output logic done_o
);
    owc_pkg::wu_s r;
    owc_pkg::wu_s n;

    always_comb begin
        n = r;
        n.done = 1'b0;
        unique case (r.state)
            owc_pkg::WU_IDLE: begin
            end
            owc_pkg::WU_COUNT: begin
                if (r.cnt >= r.target) begin // see [R18]
                    n.state = owc_pkg::WU_IDLE;
                    n.done = 1'b1;
                end else if (tick_i) begin
                    n.cnt = r.cnt + 16'h0001;
                end
            end
        endcase
        // A start while counting throws away the partial count. see [R18]
        if (start_i) begin
            n.state = owc_pkg::WU_COUNT;
            n.cnt = 16'h0000;
            n.target = target_i; // see [R16]
            n.done = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= '{state: owc_pkg::WU_IDLE, done: 1'b0, cnt: 16'h0000, target: 16'h0000};
        end else begin
            r <= n;
        end
    end

    assign busy_o = r.state[1];
    assign done_o = r.done;

    property p_start_busy;
        @(posedge clk_i) disable iff (!rst_b_i)
        start_i |=> busy_o && r.cnt == 16'h0000;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start did not arm the timer"); // see [R18]

    property p_reach_done;
        @(posedge clk_i) disable iff (!rst_b_i)
        busy_o && r.cnt >= r.target && !start_i |=> !busy_o && done_o;
    endproperty
    a_reach_done: assert property (p_reach_done) else $error("timer missed its count"); // see [R18]

endmodule

//--- design/oscillator_warmup_control.sv
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "owc_consts.svh"
// Behaviour
// [R1] Oscillator bit 17 picks high-speed source: 0 internal, 1 external.
// [R2] Software should stop the internal oscillator after switching to external.
// [R3] Oscillator bit 16 runs (1) or stops (0) the internal high-speed oscillator.
// [R4] Bits 15-14 hold warm-up count low part; software writes 00 for high-speed.
// [R5] Oscillator bit 11 enables the external high-speed clock input.
// [R6] Oscillator bit 10 picks low-speed source: 0 crystal, 1 clock pin.
// [R7] Oscillator bit 9 runs or stops the external low-speed oscillator.
// [R8] Oscillator bit 8 runs or stops the external high-speed oscillator.
// [R9] Oscillator bit 3 picks warm-up clock: 0 high-speed, 1 low-speed.
// [R10] Oscillator bit 1 reads 1 while warm-up counts, 0 when finished.
// [R11] Writing 1 to oscillator bit 0 starts warm-up; it reads 0.
// [R12] The external high-speed clock pin never clocks the warm-up timer.
// [R13] Standby register resets with bit 8 set and mode field 011.
// [R14] Mode field codes: 001 STOP, 010 SLEEP, 011 IDLE, others reserved.
// [R15] Standby bits 8 and 9 set oscillators after STOP release if not system clock.
// [R16] Warm-up timer is 16 bits, upper 12 from the high count field.
// [R17] Standby bit 16 keeps pin drivers active during STOP.
// [R18] Timer counts warm-up clock ticks to the target, then clears the flag.
module oscillator_warmup_control (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // AHB-Lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Oscillator ticks, one-cycle pulses per oscillator period
    input wire logic INTERNAL_HS_OSCILLATOR_TICK_I,
    input wire logic EHOSC_TICK_I,
    input wire logic ELOSC_TICK_I,
    input wire logic ELCLKIN_TICK_I,
    // Power management
    input wire logic STOP_RELEASE_I,
    input wire logic HS_IS_SYSCLK_I,
    input wire logic LS_IS_SYSCLK_I,
    // Oscillator controls
    output logic INTERNAL_HS_OSC_ENABLE_O,
    output logic EXT_HS_OSC_ENABLE_O,
    output logic EXT_LS_OSC_ENABLE_O,
    output logic EXT_HS_CLOCK_INPUT_ENABLE_O,
    output logic HS_SOURCE_SELECT_O,
    output logic LS_SOURCE_SELECT_O,
    // Standby controls
    output logic [2:0] LOW_POWER_MODE_SELECT_O,
    output logic STOP_PIN_DRIVE_KEEP_O,
    output logic HS_OSC_AFTER_STOP_O,
    output logic LS_OSC_AFTER_STOP_O,
    // Status
    output logic WARMUP_ACTIVE_FLAG_O,
    output logic IRQ_O
);
    owc_pkg::ctl_s r;
    owc_pkg::ctl_s n;
    logic accept;
    logic hs_tick;
    logic ls_tick;
    logic wu_tick;
    logic wu_start;
    logic wu_busy;
    logic wu_done;
    logic [1:0] clr;
    logic [1:0] ev;
    logic [15:0] target;

    function automatic logic [31:0] read_reg(input logic [7:0] addr, input owc_pkg::ctl_s s,
                                              input logic busy);
        logic [31:0] v;
        v = 32'h00000000;
        unique case (addr)
            `OWC_OSC_OFS: begin
                v = s.osc;
                v[`OWC_WU_FLAG_BIT] = busy; // see [R10]
                v[`OWC_WU_START_BIT] = 1'b0; // see [R11]
            end
            `OWC_LOW_POWER_MODE_SELECT_OFS: v = s.low_power_mode_select;
            `OWC_STAT_OFS: v[1:0] = s.stat;
            `OWC_MASK_OFS: v[1:0] = s.mask;
            default: v = 32'h00000000;
        endcase
        return v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [31:0] wmask);
        return (old & ~wmask) | (wd & wmask);
    endfunction

    assign accept = HSEL_I && HREADY_I && HTRANS_I[1];

    // The high-speed warm-up source comes only from the two oscillators, so the
    // external high-speed clock pin can never drive the timer. see [R12]
    assign hs_tick = r.osc[`OWC_WU_HS_SRC_BIT] ? EHOSC_TICK_I : INTERNAL_HS_OSCILLATOR_TICK_I;
    assign ls_tick = r.osc[`OWC_LS_SRC_BIT] ? ELCLKIN_TICK_I : ELOSC_TICK_I; // see [R6]
    assign wu_tick = r.osc[`OWC_WU_SPEED_BIT] ? ls_tick : hs_tick; // see [R9]

    always_comb begin
        n = r;
        clr = 2'h0;
        wu_start = 1'b0;
        // Writes land at the end of the data phase.
        if (r.ph_wr) begin
            unique case (r.ph_addr)
                `OWC_OSC_OFS: begin
                    // The low count field is stored as written. see [R4]
                    n.osc = merge(r.osc, HWDATA_I, `OWC_OSC_WMASK);
                    wu_start = HWDATA_I[`OWC_WU_START_BIT]; // see [R11]
                end
                `OWC_LOW_POWER_MODE_SELECT_OFS: n.low_power_mode_select = merge(r.low_power_mode_select, HWDATA_I, `OWC_LOW_POWER_MODE_SELECT_WMASK);
                `OWC_STAT_OFS: clr = HWDATA_I[1:0];
                `OWC_MASK_OFS: n.mask = HWDATA_I[1:0];
                default: begin
                end
            endcase
        end
        // Oscillators that are not the system clock take their standby setting on
        // release from STOP; the selected high-speed oscillator is the one affected.
        if (STOP_RELEASE_I) begin
            if (!HS_IS_SYSCLK_I) begin
                if (n.osc[`OWC_HS_SRC_BIT]) begin
                    n.osc[`OWC_EXT_HS_EN_BIT] = r.low_power_mode_select[`OWC_HS_AFTER_BIT]; // see [R15]
                end else begin
                    n.osc[`OWC_INT_HS_EN_BIT] = r.low_power_mode_select[`OWC_HS_AFTER_BIT]; // see [R15]
                end
            end
            if (!LS_IS_SYSCLK_I) begin
                n.osc[`OWC_EXT_LS_EN_BIT] = r.low_power_mode_select[`OWC_LS_AFTER_BIT]; // see [R15]
            end
        end
        ev = 2'h0;
        ev[`OWC_EV_DONE_BIT] = wu_done;
        ev[`OWC_EV_RESTART_BIT] = wu_start && wu_busy;
        // An event in the clearing cycle survives the clear.
        n.stat = (r.stat & ~clr) | ev;
        n.irq = |(n.stat & n.mask);
        n.ph_wr = accept && HWRITE_I;
        n.ph_rd = accept && !HWRITE_I;
        if (accept) begin
            n.ph_addr = HADDR_I[7:0];
        end
        // Reads take one wait state so a preceding write is always seen.
        n.ready = !(accept && !HWRITE_I);
        if (r.ph_rd) begin
            n.rdata = read_reg(r.ph_addr, r, wu_busy);
        end
    end

    // Timer target: high field, low field, then two zero bits. see [R16]
    assign target = {n.osc[`OWC_CNT_HIGH_MSB:`OWC_CNT_HIGH_LSB],
                     n.osc[`OWC_CNT_LOW_MSB:`OWC_CNT_LOW_LSB], 2'h0};

    warmup_counter counter (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .start_i(wu_start),
        .tick_i(wu_tick),
        .target_i(target),
        .busy_o(wu_busy),
        .done_o(wu_done)
    );

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            r <= '{osc: `OWC_OSC_RST, low_power_mode_select: `OWC_LOW_POWER_MODE_SELECT_RST, stat: 2'h0, mask: 2'h0, // see [R13]
                   irq: 1'b0, ph_wr: 1'b0, ph_rd: 1'b0, ph_addr: 8'h00, ready: 1'b1,
                   rdata: 32'h00000000};
        end else begin
            r <= n;
        end
    end

    assign HRDATA_O = r.rdata;
    assign HREADYOUT_O = r.ready;
    assign HRESP_O = 1'b0;
    assign HS_SOURCE_SELECT_O = r.osc[`OWC_HS_SRC_BIT]; // see [R1]
    assign INTERNAL_HS_OSC_ENABLE_O = r.osc[`OWC_INT_HS_EN_BIT]; // see [R3]
    assign EXT_HS_CLOCK_INPUT_ENABLE_O = r.osc[`OWC_HS_CLKIN_EN_BIT]; // see [R5]
    assign LS_SOURCE_SELECT_O = r.osc[`OWC_LS_SRC_BIT]; // see [R6]
    assign EXT_LS_OSC_ENABLE_O = r.osc[`OWC_EXT_LS_EN_BIT]; // see [R7]
    assign EXT_HS_OSC_ENABLE_O = r.osc[`OWC_EXT_HS_EN_BIT]; // see [R8]
    // Reserved mode codes are passed on unchanged; the power controller ignores them.
    assign LOW_POWER_MODE_SELECT_O = r.low_power_mode_select[`OWC_LPM_MSB:`OWC_LPM_LSB]; // see [R14]
    assign STOP_PIN_DRIVE_KEEP_O = r.low_power_mode_select[`OWC_PIN_KEEP_BIT]; // see [R17]
    assign HS_OSC_AFTER_STOP_O = r.low_power_mode_select[`OWC_HS_AFTER_BIT]; // see [R15]
    assign LS_OSC_AFTER_STOP_O = r.low_power_mode_select[`OWC_LS_AFTER_BIT]; // see [R15]
    assign WARMUP_ACTIVE_FLAG_O = wu_busy; // see [R10]
    assign IRQ_O = r.irq;

    sequence s_osc_wr;
        r.ph_wr && r.ph_addr == `OWC_OSC_OFS;
    endsequence

    sequence s_low_power_mode_select_wr;
        r.ph_wr && r.ph_addr == `OWC_LOW_POWER_MODE_SELECT_OFS;
    endsequence

    property p_hs_select;
        @(posedge CLK_I) disable iff (!RST_B_I)
        s_osc_wr |=> HS_SOURCE_SELECT_O == $past(HWDATA_I[17]);
    endproperty
    a_hs_select: assert property (p_hs_select) else $error("hs source not written"); // see [R1]

    property p_int_enable;
        @(posedge CLK_I) disable iff (!RST_B_I)
        s_osc_wr ##0 !STOP_RELEASE_I |=> INTERNAL_HS_OSC_ENABLE_O == $past(HWDATA_I[16]);
    endproperty
    a_int_enable: assert property (p_int_enable) else $error("internal enable wrong"); // see [R3]

    property p_clkin_enable;
        @(posedge CLK_I) disable iff (!RST_B_I)
        s_osc_wr |=> EXT_HS_CLOCK_INPUT_ENABLE_O == $past(HWDATA_I[11]);
    endproperty
    a_clkin_enable: assert property (p_clkin_enable) else $error("clock input enable wrong"); // see [R5]

    property p_ls_select;
        @(posedge CLK_I) disable iff (!RST_B_I)
        s_osc_wr |=> LS_SOURCE_SELECT_O == $past(HWDATA_I[10]);
    endproperty
    a_ls_select: assert property (p_ls_select) else $error("ls source not written"); // see [R6]

    property p_ls_after_stop;
        @(posedge CLK_I) disable iff (!RST_B_I)
        STOP_RELEASE_I && !LS_IS_SYSCLK_I |=> EXT_LS_OSC_ENABLE_O == $past(r.low_power_mode_select[9]);
    endproperty
    a_ls_after_stop: assert property (p_ls_after_stop) else $error("ls state after stop"); // see [R15]

    property p_start_flag;
        @(posedge CLK_I) disable iff (!RST_B_I)
        s_osc_wr ##0 HWDATA_I[0] |=> WARMUP_ACTIVE_FLAG_O;
    endproperty
    a_start_flag: assert property (p_start_flag) else $error("start did not raise flag"); // see [R10]

    property p_start_reads_zero;
        @(posedge CLK_I) disable iff (!RST_B_I)
        r.ph_rd && r.ph_addr == `OWC_OSC_OFS |=> HRDATA_O[0] == 1'b0 && HREADYOUT_O;
    endproperty
    a_start_reads_zero: assert property (p_start_reads_zero) else $error("start bit read 1"); // see [R11]

    property p_pin_keep;
        @(posedge CLK_I) disable iff (!RST_B_I)
        s_low_power_mode_select_wr |=> STOP_PIN_DRIVE_KEEP_O == $past(HWDATA_I[16]) ##0
            LOW_POWER_MODE_SELECT_O == $past(HWDATA_I[2:0]);
    endproperty
    a_pin_keep: assert property (p_pin_keep) else $error("standby write lost"); // see [R17]

    property p_done_irq;
        @(posedge CLK_I) disable iff (!RST_B_I)
        wu_done |=> r.stat[0] ##0 (IRQ_O == r.mask[0] || r.stat[1]);
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("done not flagged"); // see [R18]

    property p_hs_osc_en;
        @(posedge CLK_I) disable iff (!RST_B_I)
        s_osc_wr ##0 !STOP_RELEASE_I |=> EXT_HS_OSC_ENABLE_O == $past(HWDATA_I[8]);
    endproperty
    a_hs_osc_en: assert property (p_hs_osc_en) else $error("hs osc enable wrong"); // see [R8]

    property p_ls_osc_en;
        @(posedge CLK_I) disable iff (!RST_B_I)
        s_osc_wr ##0 !STOP_RELEASE_I |=> EXT_LS_OSC_ENABLE_O == $past(HWDATA_I[9]);
    endproperty
    a_ls_osc_en: assert property (p_ls_osc_en) else $error("ls osc enable wrong"); // see [R7]

    // A high-speed tick must never advance the timer while it runs on the slow clock.
    property p_ls_wu_clock;
        @(posedge CLK_I) disable iff (!RST_B_I)
        r.osc[`OWC_WU_SPEED_BIT] && !ELOSC_TICK_I && !ELCLKIN_TICK_I |-> !wu_tick;
    endproperty
    a_ls_wu_clock: assert property (p_ls_wu_clock) else $error("stray ls tick"); // see [R9]

    property p_hs_wu_clock;
        @(posedge CLK_I) disable iff (!RST_B_I)
        !r.osc[`OWC_WU_SPEED_BIT] && !INTERNAL_HS_OSCILLATOR_TICK_I && !EHOSC_TICK_I |-> !wu_tick;
    endproperty
    a_hs_wu_clock: assert property (p_hs_wu_clock) else $error("stray hs tick"); // see [R12]

    property p_hs_after_stop;
        @(posedge CLK_I) disable iff (!RST_B_I)
        STOP_RELEASE_I && !HS_IS_SYSCLK_I && !r.ph_wr |=>
            (HS_SOURCE_SELECT_O ? EXT_HS_OSC_ENABLE_O : INTERNAL_HS_OSC_ENABLE_O) ==
            $past(HS_OSC_AFTER_STOP_O);
    endproperty
    a_hs_after_stop: assert property (p_hs_after_stop) else $error("hs after stop"); // see [R15]

    property p_flag_read;
        @(posedge CLK_I) disable iff (!RST_B_I)
        r.ph_rd && r.ph_addr == `OWC_OSC_OFS |=> HRDATA_O[1] == $past(WARMUP_ACTIVE_FLAG_O);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("busy bit wrong"); // see [R10]

    property p_target;
        @(posedge CLK_I) disable iff (!RST_B_I)
        wu_start |-> target[15:4] == HWDATA_I[31:20] && target[3:2] == HWDATA_I[15:14] &&
            target[1:0] == 2'h0;
    endproperty
    a_target: assert property (p_target) else $error("target wrong"); // see [R16]

    property p_restart_event;
        @(posedge CLK_I) disable iff (!RST_B_I)
        wu_start && wu_busy |=> r.stat[1];
    endproperty
    a_restart_event: assert property (p_restart_event) else $error("restart lost"); // see [R18]

endmodule

//--- tb/testbench.sv
`timescale 1ns/10ps
`include "owc_consts.svh"
module testbench;
    logic clk, rst_b, hsel, hwrite, stop_rel, hs_sys, ls_sys;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] ticks;
    logic [31:0] haddr, hwdata, rdata;
    wire logic [31:0] hrdata;
    wire logic hready, hresp, int_en, ehs_en, els_en, clkin_en, hs_src, ls_src;
    wire logic keep, hs_after, ls_after, flag, irq;
    wire logic [2:0] mode;
    int errors, total_checks;
    int bp[6] = '{8, 9, 10, 11, 16, 17};

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    oscillator_warmup_control uut (
        .CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .INTERNAL_HS_OSCILLATOR_TICK_I(ticks[0]), .EHOSC_TICK_I(ticks[1]), .ELOSC_TICK_I(ticks[2]),
        .ELCLKIN_TICK_I(ticks[3]), .STOP_RELEASE_I(stop_rel), .HS_IS_SYSCLK_I(hs_sys),
        .LS_IS_SYSCLK_I(ls_sys), .INTERNAL_HS_OSC_ENABLE_O(int_en),
        .EXT_HS_OSC_ENABLE_O(ehs_en), .EXT_LS_OSC_ENABLE_O(els_en),
        .EXT_HS_CLOCK_INPUT_ENABLE_O(clkin_en), .HS_SOURCE_SELECT_O(hs_src),
        .LS_SOURCE_SELECT_O(ls_src), .LOW_POWER_MODE_SELECT_O(mode),
        .STOP_PIN_DRIVE_KEEP_O(keep), .HS_OSC_AFTER_STOP_O(hs_after),
        .LS_OSC_AFTER_STOP_O(ls_after), .WARMUP_ACTIVE_FLAG_O(flag), .IRQ_O(irq)
    );

    task conclude;
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // The limit keeps a stuck slave from hanging the run long before the watchdog.
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            errors++;
            conclude;
        end
    endtask

    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        wait_rdy;
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy;
        rdata = hrdata;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        check(n, rdata, e);
    endtask

    task settle;
        @(posedge clk);
        #1;
    endtask

    task tick(input int s);
        @(posedge clk);
        ticks <= 4'h1 << s;
        @(posedge clk);
        ticks <= 4'h0;
        settle;
        settle;
    endtask

    task pulse_release;
        @(posedge clk);
        stop_rel <= 1'b1;
        @(posedge clk);
        stop_rel <= 1'b0;
        settle;
    endtask

    // Configuration i picks the tick source: internal HS, external HS, crystal, clock pin.
    task warm(input int i, input logic irq_e);
        logic spd;
        int n;
        logic [31:0] v;
        spd = (i >= 2);
        v = 32'h00110031 | (32'(i == 1) << 19) | (32'(i == 3) << 10);
        v = v | (32'(spd) << 14) | (32'(spd) << 3);
        wr(`OWC_OSC_OFS, v);
        settle;
        check("flag after start", flag, 32'h1);
        if (i == 0) begin
            wr(`OWC_OSC_OFS, v);
            rdc("restart status", `OWC_STAT_OFS, 32'h00000002);
            wr(`OWC_STAT_OFS, 32'h00000002);
        end
        for (int s = 0; s < 4; s++) begin
            if (s != i) begin
                repeat (5) tick(s);
            end
        end
        check("flag other ticks", flag, 32'h1);
        n = 0;
        while (flag === 1'b1 && n < 100) begin
            tick(i);
            n++;
        end
        check("tick count", 32'(n), 32'(16 + 4 * spd));
        check("flag done", flag, 32'h0);
        rdc("done status", `OWC_STAT_OFS, 32'h00000001);
        check("irq raised", irq, 32'(irq_e));
        wr(`OWC_STAT_OFS, 32'h00000001);
        settle;
        settle;
        check("irq cleared", irq, 32'h0);
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        $display("Watchdog expired");
        conclude;
    end

    initial begin
        rst_b = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h00000000;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        ticks = 4'h0;
        stop_rel = 1'b0;
        hs_sys = 1'b0;
        ls_sys = 1'b0;
        errors = 0;
        total_checks = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        settle;
        check("reset outputs", {flag, irq, int_en, ehs_en, els_en, hs_after, ls_after, keep},
              32'h24);
        check("reset mode", mode, 32'h3);
        check("okay response", hresp, 32'h0);
        rdc("osc reset", `OWC_OSC_OFS, 32'h80010030);
        rdc("low_power_mode_select reset", `OWC_LOW_POWER_MODE_SELECT_OFS, 32'h00000103);
        rdc("unmapped", 8'h10, 32'h00000000);
        $display("Test reset finished");
        for (int k = 0; k < 6; k++) begin
            wr(`OWC_OSC_OFS, 32'h00000030 | (32'h1 << bp[k]));
            settle;
            check("osc field outputs", {hs_src, int_en, clkin_en, ls_src, els_en, ehs_en},
                  32'h1 << k);
        end
        wr(`OWC_OSC_OFS, 32'hABCDF2F6);
        rdc("osc readback", `OWC_OSC_OFS, 32'hABCDF2F4);
        wr(`OWC_LOW_POWER_MODE_SELECT_OFS, 32'hFFFFFFFF);
        rdc("low_power_mode_select readback", `OWC_LOW_POWER_MODE_SELECT_OFS, 32'h000F0307);
        check("low_power_mode_select outputs", {keep, hs_after, ls_after}, 32'h7);
        for (int m = 1; m < 4; m++) begin
            wr(`OWC_LOW_POWER_MODE_SELECT_OFS, 32'(m));
            settle;
            check("mode output", mode, 32'(m));
        end
        $display("Test fields finished");
        wr(`OWC_MASK_OFS, 32'h00000003);
        for (int i = 0; i < 4; i++) begin
            warm(i, 1'b1);
        end
        wr(`OWC_MASK_OFS, 32'h00000000);
        warm(0, 1'b0);
        $display("Test warm-up finished");
        // Software switches to the external oscillator and stops the internal one.
        wr(`OWC_OSC_OFS, 32'h00020200);
        settle;
        check("external source", {hs_src, int_en}, 32'h2);
        wr(`OWC_LOW_POWER_MODE_SELECT_OFS, 32'h00000103);
        pulse_release;
        check("release osc", {int_en, ehs_en, els_en}, 32'h2);
        @(posedge clk);
        hs_sys <= 1'b1;
        ls_sys <= 1'b1;
        wr(`OWC_LOW_POWER_MODE_SELECT_OFS, 32'h00000200);
        pulse_release;
        check("release sysclk", {int_en, ehs_en, els_en}, 32'h2);
        @(posedge clk);
        hs_sys <= 1'b0;
        ls_sys <= 1'b0;
        pulse_release;
        check("release again", {int_en, ehs_en, els_en}, 32'h1);
        $display("Test stop release finished");
        conclude;
    end
endmodule
